// [hdl/spc_pkg.sv]
// Constants, types and helpers of the sleep and PLL power control block
package spc_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 25;

  localparam logic [7:0]  ADDR_PLL_CTRL    = 8'h49;
  localparam logic [7:0]  ADDR_PLL_FREQ    = 8'h52;
  localparam logic [7:0]  ADDR_SLEEP_CTRL  = 8'h53;
  localparam logic [7:0]  ADDR_PWR_RED0    = 8'h64;
  localparam logic [7:0]  ADDR_PWR_RED1    = 8'h65;

  localparam int unsigned PLL_LOCKED_BIT   = 0;
  localparam int unsigned PLL_ENABLE_BIT   = 1;
  localparam int unsigned PLL_HALVER_BIT   = 2;
  localparam int unsigned PLL_MUX_BIT      = 7;
  localparam int unsigned SLEEP_ARM_BIT    = 0;
  localparam int unsigned SLEEP_SEL_LSB    = 1;

  localparam int unsigned PR0_TIM0_BIT     = 5;
  localparam int unsigned PR0_TIM1_BIT     = 3;
  localparam int unsigned PR0_SPI_BIT      = 2;
  localparam int unsigned PR1_USB_BIT      = 7;
  localparam int unsigned PR1_USART_BIT    = 0;

  localparam logic [7:0]  PLL_CTRL_WMASK   = 8'h06;
  localparam logic [7:0]  PLL_FREQ_WMASK   = 8'h80;
  localparam logic [7:0]  SLEEP_CTRL_WMASK = 8'h0f;
  localparam logic [7:0]  PWR_RED0_WMASK   = 8'h2c;
  localparam logic [7:0]  PWR_RED1_WMASK   = 8'h81;
  localparam logic [7:0]  REG_RESET_VAL    = 8'h00;

  localparam logic [2:0]  SEL_IDLE         = 3'h0;
  localparam logic [2:0]  SEL_PDOWN        = 3'h2;
  localparam logic [2:0]  SEL_PSAVE        = 3'h3;
  localparam logic [2:0]  SEL_STBY         = 3'h6;
  localparam logic [2:0]  SEL_XSTBY        = 3'h7;

  localparam int unsigned PER_TIM0         = 0;
  localparam int unsigned PER_TIM1         = 1;
  localparam int unsigned PER_SPI          = 2;
  localparam int unsigned PER_USART        = 3;
  localparam int unsigned PER_USB          = 4;
  localparam int unsigned PER_N            = 5;

  localparam int unsigned PLL_LOCK_TIME_US = 2000;
  localparam int unsigned PLL_LOCK_CYC     =
    (PLL_LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOCK_W           = 17;

  localparam int unsigned TMR_W            = 13;
  localparam logic [12:0] HALT_CYC         = 13'h0004;
  localparam logic [12:0] STBY_WAKE_CYC    = 13'h0006;
  localparam logic [12:0] TOUT_CYC_0       = 13'h0006;
  localparam logic [12:0] TOUT_CYC_1       = 13'h0102;
  localparam logic [12:0] TOUT_CYC_2       = 13'h0400;
  localparam logic [12:0] TOUT_CYC_3       = 13'h1000;

  typedef enum logic [1:0] {MODE_NONE, MODE_IDLE, MODE_DEEP, MODE_STBY} spc_mode_t;
  typedef enum {ST_RUN, ST_SLEEP, ST_START, ST_HALT} spc_state_t;

  function automatic spc_mode_t spc_decode_mode(input logic [2:0] sel,
                                                input logic       crystal);
    spc_mode_t m;
    m = MODE_NONE;
    if (sel == SEL_IDLE) begin
      m = MODE_IDLE;
    end else if (sel == SEL_PDOWN || sel == SEL_PSAVE) begin
      m = MODE_DEEP;
    end else if (sel == SEL_STBY || sel == SEL_XSTBY) begin
      m = crystal ? MODE_STBY : MODE_DEEP;
    end
    return m;
  endfunction : spc_decode_mode

  function automatic logic [12:0] spc_timeout(input logic [3:0] fuses);
    logic [12:0] t;
    t = TOUT_CYC_0;
    unique case (fuses[1:0])
      2'h0: t = TOUT_CYC_0;
      2'h1: t = TOUT_CYC_1;
      2'h2: t = TOUT_CYC_2;
      2'h3: t = TOUT_CYC_3;
    endcase
    return t;
  endfunction : spc_timeout

endpackage : spc_pkg

// [hdl/spc_top.sv]
// Sleep mode controller, PLL control and peripheral clock gating
`timescale 1ns/10ps
// How it works
// - halver bit selects PLL input divide one/two
// - PLL enable starts PLL, forces RC oscillator only with source mux bit set
// - lock flag after lock time, cleared by disable
// - sleep only when armed at sleep instruction
// - 000 idle, 010 and 011 power-down
// - 110 standby with crystal, six-cycle wake
// - 111 extended standby equals standby
// - wake, halt four cycles, then take interrupt
// - state kept; reset wakes to reset vector
// - idle stops CPU and flash clocks only
// - idle wakes on every interrupt source
// - deep sleep stops clocks, few wake sources
// - of USB sources only async wake leaves deep sleep
// - power-down wake waits fuse-selected time-out
// - reduction bit stops clock, blocks register access
// - clearing reduction bit resumes frozen state
// - clock gating works in active and idle
// - reserved encodings; control resets zero, upper zero
module spc_top
  import spc_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = spc_pkg::PLL_LOCK_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        sleep_instr,
  input  wire logic                        crystal_clock_sel,
  input  wire logic [3:0]                  clock_source_fuses,
  input  wire logic [3:0]                  ext_irq_low,
  input  wire logic [3:0]                  ext_irq_high_level,
  input  wire logic [3:0]                  ext_irq_high_edge,
  input  wire logic [12:0]                 pin_change_irqs,
  input  wire logic                        mem_ready_irq,
  input  wire logic                        wdt_irq,
  input  wire logic                        other_io_irq,
  input  wire logic                        usb_sync_irq,
  input  wire logic                        usb_frame_start_irq,
  input  wire logic                        usb_wakeup_irq,
  input  wire logic                        wake_reset_req,
  output logic                             cpu_clk_en,
  output logic                             flash_clk_en,
  output logic                             io_clk_en,
  output logic                             main_osc_en,
  output logic                             sleeping,
  output logic                             cpu_irq_go,
  output logic                             cpu_reset_vec,
  output logic                             pll_run,
  output logic                             pll_ref_div2,
  output logic                             rc_osc_req,
  output logic                             pll_locked,
  output logic      [spc_pkg::PER_N-1:0]   periph_clk_en,
  output logic      [spc_pkg::PER_N-1:0]   periph_io_en
);

  // Register file
  logic [7:0]        pll_ctrl_r;
  logic [7:0]        pll_frequency_reg_r;
  logic [7:0]        sleep_control_reg_r;
  logic [7:0]        power_reduction_reg0_r;
  logic [7:0]        power_reduction_reg1_r;
  logic [7:0]        reg_rdata_r;
  logic              pll_locked_flag_r;
  logic [LOCK_W-1:0] lock_cnt_r;

  // Sleep controller state
  spc_state_t        state_r;
  spc_state_t        state_nxt;
  spc_mode_t         mode_r;
  spc_mode_t         mode_nxt;

  // Output flops
  logic              cpu_clk_en_r;
  logic              flash_clk_en_r;
  logic              io_clk_en_r;
  logic              main_osc_en_r;
  logic              sleeping_r;
  logic              cpu_irq_go_r;
  logic              cpu_reset_vec_r;
  logic              pll_run_r;
  logic              pll_ref_div2_r;
  logic              rc_osc_req_r;
  logic [PER_N-1:0]  periph_clk_en_r;
  logic [PER_N-1:0]  periph_io_en_r;

  // Wake timer hookup
  logic              tmr_load;
  logic [TMR_W-1:0]  tmr_count;
  logic              tmr_done;

  // Address decode
  wire logic wr_pll_ctrl  = reg_wr && (reg_addr == ADDR_PLL_CTRL);
  wire logic wr_pll_freq  = reg_wr && (reg_addr == ADDR_PLL_FREQ);
  wire logic wr_sleep     = reg_wr && (reg_addr == ADDR_SLEEP_CTRL);
  wire logic wr_pwr_red0  = reg_wr && (reg_addr == ADDR_PWR_RED0);
  wire logic wr_pwr_red1  = reg_wr && (reg_addr == ADDR_PWR_RED1);

  // Control fields
  wire logic       pll_enable_bit    = pll_ctrl_r[PLL_ENABLE_BIT];
  wire logic       pll_input_halver  = pll_ctrl_r[PLL_HALVER_BIT];
  wire logic       pll_source_mux    = pll_frequency_reg_r[PLL_MUX_BIT];
  wire logic       sleep_arm_bit     = sleep_control_reg_r[SLEEP_ARM_BIT];
  wire logic [2:0] sleep_select_field = sleep_control_reg_r[SLEEP_SEL_LSB +: 3];
  wire spc_mode_t  sel_mode          = spc_decode_mode(sleep_select_field,
                                                       crystal_clock_sel);
  wire logic [LOCK_W-1:0] lock_last  = LOCK_W'(LOCK_CYCLES - 1);

  // Read data
  wire logic [7:0] pll_ctrl_rd = {pll_ctrl_r[7:1], pll_locked_flag_r};
  wire logic [7:0] rd_mux =
    (reg_addr == ADDR_PLL_CTRL)   ? pll_ctrl_rd :
    (reg_addr == ADDR_PLL_FREQ)   ? pll_frequency_reg_r :
    (reg_addr == ADDR_SLEEP_CTRL) ? sleep_control_reg_r :
    (reg_addr == ADDR_PWR_RED0)   ? power_reduction_reg0_r :
    (reg_addr == ADDR_PWR_RED1)   ? power_reduction_reg1_r : 8'h00;

  // Wake qualification
  wire logic deep_wake = (|ext_irq_low) || (|ext_irq_high_level) ||
                         (|pin_change_irqs) || wdt_irq ||
                         usb_wakeup_irq;
  wire logic idle_wake = deep_wake || (|ext_irq_high_edge) ||
                         mem_ready_irq || other_io_irq ||
                         usb_sync_irq || usb_frame_start_irq;

  // Deep modes hear only async sources
  wire logic wake_now  = (mode_r == MODE_IDLE) ? idle_wake : deep_wake;
  wire logic sleep_go  = sleep_instr && sleep_arm_bit &&
                         (sel_mode != MODE_NONE);

  // Peripheral gate vector
  wire logic [PER_N-1:0] per_reduce = {power_reduction_reg1_r[PR1_USB_BIT],
                                       power_reduction_reg1_r[PR1_USART_BIT],
                                       power_reduction_reg0_r[PR0_SPI_BIT],
                                       power_reduction_reg0_r[PR0_TIM1_BIT],
                                       power_reduction_reg0_r[PR0_TIM0_BIT]};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pll_ctrl_r             <= REG_RESET_VAL;
      pll_frequency_reg_r    <= REG_RESET_VAL;
    end else begin
      if (wr_pll_ctrl) begin
        pll_ctrl_r <= reg_wdata & PLL_CTRL_WMASK;
      end
      if (wr_pll_freq) begin
        pll_frequency_reg_r <= reg_wdata & PLL_FREQ_WMASK;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sleep_control_reg_r    <= REG_RESET_VAL;
      power_reduction_reg0_r <= REG_RESET_VAL;
      power_reduction_reg1_r <= REG_RESET_VAL;
    end else begin
      if (wr_sleep) begin
        sleep_control_reg_r <= reg_wdata & SLEEP_CTRL_WMASK;
      end
      if (wr_pwr_red0) begin
        power_reduction_reg0_r <= reg_wdata & PWR_RED0_WMASK;
      end
      if (wr_pwr_red1) begin
        power_reduction_reg1_r <= reg_wdata & PWR_RED1_WMASK;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Lock detector
  // Flag held until enable clears
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lock_cnt_r        <= '0;
      pll_locked_flag_r <= 1'b0;
    end else if (!pll_enable_bit) begin
      lock_cnt_r        <= '0;
      pll_locked_flag_r <= 1'b0;
    end else if (!pll_locked_flag_r) begin
      lock_cnt_r        <= lock_cnt_r + LOCK_W'(1);
      pll_locked_flag_r <= (lock_cnt_r >= lock_last);
    end
  end

  // Sleep sequencing
  always_comb begin
    state_nxt       = state_r;
    mode_nxt        = mode_r;
    tmr_load        = 1'b0;
    tmr_count       = HALT_CYC;
    unique case (state_r)
      ST_RUN: begin
        if (sleep_go) begin
          state_nxt = ST_SLEEP;
          mode_nxt  = sel_mode;
        end
      end
      ST_SLEEP: begin
        if (wake_now) begin
          tmr_load = 1'b1;
          if (mode_r == MODE_IDLE) begin
            state_nxt = ST_HALT;
            tmr_count = HALT_CYC;
          end else begin
            state_nxt = ST_START;
            tmr_count = (mode_r == MODE_STBY) ? STBY_WAKE_CYC :
                        spc_timeout(clock_source_fuses);
          end
        end
      end
      ST_START: begin
        if (tmr_done) begin
          state_nxt = ST_HALT;
          tmr_load  = 1'b1;
          tmr_count = HALT_CYC;
        end
      end
      ST_HALT: begin
        if (tmr_done) begin
          state_nxt = ST_RUN;
          mode_nxt  = MODE_NONE;
        end
      end
    endcase
    // Reset wake beats any sequence
    if (wake_reset_req && state_r != ST_RUN) begin
      state_nxt = ST_RUN;
      mode_nxt  = MODE_NONE;
      tmr_load  = 1'b0;
    end
  end

  // Clock domain enables for the next state
  wire logic run_nxt   = (state_nxt == ST_RUN);
  wire logic idle_nxt  = (mode_nxt == MODE_IDLE);
  wire logic io_nxt    = run_nxt || (state_nxt == ST_HALT) || idle_nxt;
  wire logic osc_nxt   = run_nxt || (state_nxt == ST_HALT) || idle_nxt ||
                         (mode_nxt == MODE_STBY) ||
                         (state_nxt == ST_START);

  // CPU pulses
  wire logic go_nxt    = (state_r == ST_HALT) && tmr_done && !wake_reset_req;
  wire logic rst_nxt   = wake_reset_req && (state_r != ST_RUN);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r         <= ST_RUN;
      mode_r          <= MODE_NONE;
    end else begin
      state_r         <= state_nxt;
      mode_r          <= mode_nxt;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cpu_clk_en_r    <= 1'b1;
      flash_clk_en_r  <= 1'b1;
      io_clk_en_r     <= 1'b1;
      main_osc_en_r   <= 1'b1;
      sleeping_r      <= 1'b0;
    end else begin
      cpu_clk_en_r    <= run_nxt;
      flash_clk_en_r  <= run_nxt;
      io_clk_en_r     <= io_nxt;
      main_osc_en_r   <= osc_nxt;
      sleeping_r      <= !run_nxt;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cpu_irq_go_r    <= 1'b0;
      cpu_reset_vec_r <= 1'b0;
    end else begin
      cpu_irq_go_r    <= go_nxt;
      cpu_reset_vec_r <= rst_nxt;
    end
  end

  // PLL control outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pll_run_r       <= 1'b0;
      pll_ref_div2_r  <= 1'b0;
      rc_osc_req_r    <= 1'b0;
    end else begin
      pll_run_r       <= pll_enable_bit;
      pll_ref_div2_r  <= pll_input_halver;
      // Stays on in sleep while enabled, hence the disable before power-down
      rc_osc_req_r    <= pll_enable_bit && pll_source_mux;
    end
  end

  // Peripheral gates
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      periph_clk_en_r <= '0;
      periph_io_en_r  <= '0;
    end else begin
      periph_clk_en_r <= ~per_reduce & {PER_N{io_nxt}};
      periph_io_en_r  <= ~per_reduce;
    end
  end

  spc_wake_timer u_wake_timer (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (tmr_load),
    .count  (tmr_count),
    .done   (tmr_done),
    .busy   ()
  );

  assign reg_rdata     = reg_rdata_r;
  assign cpu_clk_en    = cpu_clk_en_r;
  assign flash_clk_en  = flash_clk_en_r;
  assign io_clk_en     = io_clk_en_r;
  assign main_osc_en   = main_osc_en_r;
  assign sleeping      = sleeping_r;
  assign cpu_irq_go    = cpu_irq_go_r;
  assign cpu_reset_vec = cpu_reset_vec_r;
  assign pll_run       = pll_run_r;
  assign pll_ref_div2  = pll_ref_div2_r;
  assign rc_osc_req    = rc_osc_req_r;
  assign pll_locked    = pll_locked_flag_r;
  assign periph_clk_en = periph_clk_en_r;
  assign periph_io_en  = periph_io_en_r;

endmodule : spc_top

// [hdl/spc_wake_timer.sv]
// Down counter that times start-up and halt delays
`timescale 1ns/10ps
module spc_wake_timer
  import spc_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   load,
  input  wire logic [spc_pkg::TMR_W-1:0] count,
  output logic                        done,
  output logic                        busy
);

  logic [TMR_W-1:0] cnt_r;
  logic             busy_r;
  wire  logic       last_tick = busy_r && (cnt_r <= {{(TMR_W-1){1'b0}}, 1'b1});

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else if (load) begin
      cnt_r  <= count;
      busy_r <= 1'b1;
    end else begin
      cnt_r  <= busy_r ? cnt_r - {{(TMR_W-1){1'b0}}, 1'b1} : cnt_r;
      busy_r <= busy_r && !last_tick;
    end
  end

  // Comb done: a load of N spans N cycles
  assign done = last_tick;
  assign busy = busy_r;

endmodule : spc_wake_timer

// [sim/spc_top_bench.sv]
// Self-checking bench for the sleep and PLL power control block
`timescale 1ns/10ps
module spc_top_bench;
  import spc_pkg::*;
  localparam int unsigned LOCKN = 16;
  logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sleep_instr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic crystal_clock_sel = 1'b0, mem_ready_irq = 1'b0, wdt_irq = 1'b0, other_io_irq = 1'b0;
  logic usb_sync_irq = 1'b0, usb_frame_start_irq = 1'b0, usb_wakeup_irq = 1'b0;
  logic wake_reset_req = 1'b0;
  logic [3:0] clock_source_fuses = 4'h0, ext_irq_low = 4'h0, ext_irq_high_level = 4'h0;
  logic [3:0] ext_irq_high_edge = 4'h0;
  logic [12:0] pin_change_irqs = 13'h0000;
  logic cpu_clk_en, flash_clk_en, io_clk_en, main_osc_en, sleeping, cpu_irq_go, cpu_reset_vec;
  logic pll_run, pll_ref_div2, rc_osc_req, pll_locked;
  logic [PER_N-1:0] periph_clk_en, periph_io_en;
  logic [12:0] tout [4] = '{TOUT_CYC_0, TOUT_CYC_1, TOUT_CYC_2, TOUT_CYC_3};
  int err_count = 0;
  int samples_checked = 0;

  spc_top #(.LOCK_CYCLES(LOCKN)) dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sleep_instr, .crystal_clock_sel, .clock_source_fuses, .ext_irq_low,
    .ext_irq_high_level, .ext_irq_high_edge, .pin_change_irqs, .mem_ready_irq, .wdt_irq,
    .other_io_irq, .usb_sync_irq, .usb_frame_start_irq, .usb_wakeup_irq, .wake_reset_req,
    .cpu_clk_en, .flash_clk_en, .io_clk_en, .main_osc_en, .sleeping, .cpu_irq_go,
    .cpu_reset_vec, .pll_run, .pll_ref_div2, .rc_osc_req, .pll_locked, .periph_clk_en,
    .periph_io_en);

  always #12.5 mclk = ~mclk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp, "read data");
  endtask : rdchk

  task automatic sleep_go;
    @(posedge mclk);
    sleep_instr <= 1'b1;
    @(posedge mclk);
    sleep_instr <= 1'b0;
    #1;
  endtask : sleep_go

  task automatic settle;
    @(posedge mclk);
    #1;
  endtask : settle

  task automatic set_src(input int i, input logic v);
    case (i)
      0: ext_irq_low[0] <= v;
      1: ext_irq_high_level[3] <= v;
      2: pin_change_irqs[12] <= v;
      3: wdt_irq <= v;
      4: usb_wakeup_irq <= v;
      5: ext_irq_high_edge[1] <= v;
      6: mem_ready_irq <= v;
      7: other_io_irq <= v;
      8: usb_sync_irq <= v;
      default: usb_frame_start_irq <= v;
    endcase
  endtask : set_src

  task automatic wait_go(output int n, input int lim);
    n = 0;
    while (cpu_irq_go !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    if (cpu_irq_go !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t wake timeout", $time);
      report_and_stop();
    end
  endtask : wait_go

  task automatic t_regs;
    rdchk(ADDR_SLEEP_CTRL, 8'h00);
    rdchk(ADDR_PLL_CTRL, 8'h00);
    wr(ADDR_SLEEP_CTRL, 8'hfe);
    rdchk(ADDR_SLEEP_CTRL, 8'h0e);
    wr(ADDR_PWR_RED0, 8'hff);
    wr(ADDR_PWR_RED1, 8'hff);
    settle();
    chk({periph_io_en, periph_clk_en}, 10'h000, "gated");
    rdchk(ADDR_PWR_RED0, 8'h2c);
    rdchk(ADDR_PWR_RED1, 8'h81);
    wr(ADDR_PWR_RED0, 8'h00);
    settle();
    chk(periph_io_en, 5'h07, "partial ungate");
    wr(8'h70, 8'hff);
    rdchk(8'h70, 8'h00);
    wr(ADDR_PWR_RED1, 8'h00);
    $display("registers done");
  endtask : t_regs

  task automatic t_pll;
    int n;
    wr(ADDR_PLL_FREQ, 8'h80);
    wr(ADDR_PLL_CTRL, 8'hff);
    settle();
    chk({pll_run, pll_ref_div2, rc_osc_req, pll_locked}, 4'he, "pll start");
    n = 0;
    while (pll_locked !== 1'b1 && n < LOCKN + 8) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(n >= LOCKN - 2 && n <= LOCKN + 2, 1'b1, "lock time");
    if (pll_locked !== 1'b1) report_and_stop();
    rdchk(ADDR_PLL_CTRL, 8'h07);
    wr(ADDR_PLL_CTRL, 8'h02);
    wr(ADDR_PLL_FREQ, 8'h00);
    settle();
    chk({pll_run, pll_ref_div2, rc_osc_req, pll_locked}, 4'h9, "halver off");
    // PLL off before any deep sleep
    wr(ADDR_PLL_CTRL, 8'h00);
    settle();
    chk(pll_locked, 1'b0, "lock cleared");
    $display("pll done");
  endtask : t_pll

  task automatic t_idle;
    int n;
    logic [2:0] rsv [3] = '{3'h1, 3'h4, 3'h5};
    wr(ADDR_PWR_RED1, 8'h81);
    wr(ADDR_SLEEP_CTRL, 8'h00);
    sleep_go();
    chk({sleeping, cpu_clk_en}, 2'h1, "unarmed");
    foreach (rsv[k]) begin
      wr(ADDR_SLEEP_CTRL, {4'h0, rsv[k], 1'b1});
      sleep_go();
      chk(sleeping, 1'b0, "reserved mode");
    end
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_SLEEP_CTRL, 8'h01);
      sleep_go();
      chk({sleeping, cpu_clk_en, flash_clk_en, io_clk_en, main_osc_en}, 5'h13, "idle");
      chk(periph_clk_en, 5'h07, "idle gating");
      @(posedge mclk);
      set_src(i, 1'b1);
      wait_go(n, 50);
      chk(n >= 4 && n <= 6, 1'b1, "idle wake");
      set_src(i, 1'b0);
    end
    wr(ADDR_PWR_RED1, 8'h00);
    settle();
    chk(periph_clk_en, 5'h1f, "ungated");
    $display("idle done");
  endtask : t_idle

  task automatic deep_run(input int i, input logic [2:0] sel, input logic xt, input logic [3:0] fz);
    int n;
    logic [12:0] t;
    t = (xt && sel[2]) ? STBY_WAKE_CYC : tout[fz[1:0]];
    @(posedge mclk);
    crystal_clock_sel  <= xt;
    clock_source_fuses <= fz;
    wr(ADDR_SLEEP_CTRL, {4'h0, sel, 1'b1});
    sleep_go();
    chk({sleeping, main_osc_en}, {1'b1, xt && sel[2]}, "deep osc");
    chk({io_clk_en, periph_clk_en}, 6'h00, "deep clocks");
    @(posedge mclk);
    for (int k = 5; k < 10; k++) set_src(k, 1'b1);
    repeat (10) @(posedge mclk);
    #1 chk(sleeping, 1'b1, "idle-only source");
    for (int k = 5; k < 10; k++) set_src(k, 1'b0);
    // Level held until wake
    set_src(i, 1'b1);
    wait_go(n, 5000);
    chk(n >= t + 4 && n <= t + 7, 1'b1, "deep wake time");
    set_src(i, 1'b0);
    $display("deep run %0d done", i);
  endtask : deep_run

  task automatic t_rwake;
    wr(ADDR_SLEEP_CTRL, 8'h05);
    sleep_go();
    @(posedge mclk);
    wake_reset_req <= 1'b1;
    settle();
    chk({sleeping, cpu_reset_vec, cpu_clk_en, main_osc_en}, 4'h7, "reset wake");
    wake_reset_req <= 1'b0;
    rdchk(ADDR_SLEEP_CTRL, 8'h05);
    $display("reset wake done");
  endtask : t_rwake

  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_pll();
    t_idle();
    deep_run(0, SEL_PDOWN, 1'b0, 4'h0);
    deep_run(1, SEL_PSAVE, 1'b0, 4'h1);
    deep_run(2, SEL_STBY, 1'b0, 4'h2);
    deep_run(3, SEL_STBY, 1'b1, 4'h3);
    deep_run(4, SEL_XSTBY, 1'b1, 4'h0);
    t_rwake();
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    $display("[ERR] %0t run limit reached", $time);
    report_and_stop();
  end
endmodule : spc_top_bench

// [sim/spc_top_sva.sv]
// Concurrent checks on the ports of the sleep and PLL power control block
`timescale 1ns/10ps
module spc_top_sva
  import spc_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = 16
) (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sleep_instr,
  input wire logic       crystal_clock_sel,
  input wire logic       usb_sync_irq,
  input wire logic       wake_reset_req,
  input wire logic       cpu_clk_en,
  input wire logic       flash_clk_en,
  input wire logic       io_clk_en,
  input wire logic       main_osc_en,
  input wire logic       sleeping,
  input wire logic       cpu_irq_go,
  input wire logic       cpu_reset_vec,
  input wire logic       pll_run,
  input wire logic       rc_osc_req,
  input wire logic       pll_locked
);
  logic [3:0]  sc_r;
  logic        mux_r;
  logic [31:0] en_cnt_r;
  wire  [2:0]  sel   = sc_r[3:1];
  wire         legal = (sel == SEL_IDLE) || (sel == SEL_PDOWN) || (sel == SEL_PSAVE) ||
                       (sel[2:1] == 2'b11);
  wire         armed = sc_r[0] && legal;

  // Shadow of sleep control and source mux
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sc_r <= 4'h0;
    end else if (reg_wr && reg_addr == ADDR_SLEEP_CTRL) begin
      sc_r <= reg_wdata[3:0];
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mux_r <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_PLL_FREQ) begin
      mux_r <= reg_wdata[PLL_MUX_BIT];
    end
  end
  // Cycles with PLL running
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      en_cnt_r <= 32'h00000000;
    end else if (!pll_run) begin
      en_cnt_r <= 32'h00000000;
    end else if (en_cnt_r != 32'hffffffff) begin
      en_cnt_r <= en_cnt_r + 32'h00000001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_idle_wait;
    sleeping && io_clk_en && sel == SEL_IDLE && $rose(usb_sync_irq) && !wake_reset_req;
  endsequence
  sequence s_go_pulse;
    ##[4:6] cpu_irq_go ##1 !cpu_irq_go;
  endsequence

  a_unarmed_noop: assert property (
    !sleeping && sleep_instr && !armed |=> !sleeping && cpu_clk_en)
    else $error("sleep taken while unarmed");
  a_sleep_entry: assert property (
    !sleeping && sleep_instr && armed |=> sleeping && !cpu_clk_en && !flash_clk_en)
    else $error("armed sleep not entered");
  a_idle_clocks: assert property (
    $rose(sleeping) && sel == SEL_IDLE |-> io_clk_en && main_osc_en)
    else $error("idle stopped io or oscillator");
  a_deep_clocks: assert property (
    $rose(sleeping) && (sel == SEL_PDOWN || sel == SEL_PSAVE) |-> !io_clk_en && !main_osc_en)
    else $error("deep sleep left clocks running");
  a_stby_osc: assert property (
    $rose(sleeping) && sel[2:1] == 2'b11 |-> main_osc_en == crystal_clock_sel)
    else $error("standby oscillator wrong");
  a_idle_wake: assert property (
    s_idle_wait |-> s_go_pulse)
    else $error("idle wake timing wrong");
  a_go_resume: assert property (
    cpu_irq_go |-> !sleeping && cpu_clk_en && flash_clk_en)
    else $error("interrupt go while halted");
  a_reset_wake: assert property (
    sleeping && wake_reset_req |=> !sleeping && cpu_reset_vec ##1 !cpu_reset_vec)
    else $error("reset wake wrong");
  a_rc_request: assert property (
    rc_osc_req == (pll_run && $past(mux_r)))
    else $error("rc oscillator request wrong");
  a_lock_clear: assert property (
    $fell(pll_run) |-> ##[0:1] !pll_locked)
    else $error("lock flag kept after disable");
  a_lock_time: assert property (
    $rose(pll_locked) |-> pll_run && en_cnt_r >= LOCK_CYCLES - 2)
    else $error("lock flag too early");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule : spc_top_sva

bind spc_top spc_top_sva #(.LOCK_CYCLES(LOCK_CYCLES)) u_sva (
  .mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_instr,
  .crystal_clock_sel, .usb_sync_irq, .wake_reset_req, .cpu_clk_en, .flash_clk_en, .io_clk_en,
  .main_osc_en, .sleeping, .cpu_irq_go, .cpu_reset_vec, .pll_run, .rc_osc_req, .pll_locked
);
